/* hw/rxa_word_align_top.sv */
// Receive channel front end: lock-mode choice, lock flags, run length check,
// deserialiser and word aligner, with a Wishbone register slave.
// Assumes recovered bits arrive synchronous to mclk_in, one per ser_valid_in.
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`include "rxa_map.svh"
module rxa_word_align_top #(
    parameter int RUN_W = 8
) (
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    // Wishbone slave
    input  wire logic              wb_cyc_in,
    input  wire logic              wb_stb_in,
    input  wire logic              wb_we_in,
    input  wire logic [3:0]        wb_adr_in,
    input  wire logic [3:0]        wb_sel_in,
    input  wire logic [31:0]       wb_dat_in,
    output logic [31:0]            wb_dat_out,
    output logic                   wb_ack_out,
    // Loop monitors
    input  wire logic [10:0]       ppm_err_in,
    input  wire logic [9:0]        phase_err_mui_in,
    input  wire logic              ref_pll_lock_in,
    // Recovered serial stream
    input  wire logic              ser_bit_in,
    input  wire logic              ser_valid_in,
    // Fabric controls
    input  wire logic              slip_in,
    input  wire logic              realign_in,
    input  wire logic              align_en_in,
    // Status and data
    output logic                   lock_to_data_out,
    output logic                   freq_locked_out,
    output logic                   rx_locked_n_out,
    output logic                   powerdown_out,
    output logic                   aligned_out,
    output logic                   sync_out,
    output logic                   run_viol_out,
    output rxa_pkg::rxa_word_t     word_out
);
    // Refused at elaboration: a narrower run counter could not reach the largest limit.
    if (RUN_W < 8) begin : g_bad_run_w
        $error("RUN_W must hold a count of 160");
    end

    rxa_pkg::rxa_st_t s_r;
    rxa_pkg::rxa_st_t s_nxt;

    // Configuration fields.
    logic              f_ref;
    logic              f_data;
    logic              used;
    logic              w10;
    logic [1:0]        ppm_sel;
    rxa_pkg::rxa_align_t mode;
    rxa_pkg::rxa_proto_t proto;
    logic              plong;
    logic              m7;
    logic [4:0]        rl_field;
    assign f_ref    = s_r.ctrl[`RXA_C_FREF];
    assign f_data   = s_r.ctrl[`RXA_C_FDATA];
    assign used     = s_r.ctrl[`RXA_C_USED];
    assign w10      = s_r.ctrl[`RXA_C_W10];
    assign ppm_sel  = s_r.ctrl[`RXA_C_PPM +: 2];
    assign mode     = rxa_pkg::rxa_align_t'(s_r.ctrl[`RXA_C_MODE +: 3]);
    assign proto    = rxa_pkg::rxa_proto_t'(s_r.ctrl[`RXA_C_PROTO +: 2]);
    assign plong    = s_r.ctrl[`RXA_C_LONG];
    assign m7       = s_r.ctrl[`RXA_C_MATCH7];
    assign rl_field = s_r.ctrl[`RXA_C_RUNLEN +: 5];

    logic [10:0] ppm_thr;
    always_comb begin
        case (ppm_sel)
            2'h0:    ppm_thr = `RXA_PPM_125;
            2'h1:    ppm_thr = `RXA_PPM_250;
            2'h2:    ppm_thr = `RXA_PPM_500;
            default: ppm_thr = `RXA_PPM_1000;
        endcase
    end
    logic freq_ok;
    logic phase_ok;
    logic auto_m;
    assign freq_ok  = ppm_err_in <= ppm_thr;
    assign phase_ok = phase_err_mui_in <= `RXA_PHASE_MUI;
    assign auto_m   = !f_data && !f_ref;

    // Illegal mode and protocol pairs leave the aligner frozen.
    logic cfg_ok;
    always_comb begin
        case (mode)
            rxa_pkg::RXA_AL_SLIP: cfg_ok = proto == rxa_pkg::RXA_PR_CUSTOM
                || proto == rxa_pkg::RXA_PR_SONET;
            rxa_pkg::RXA_AL_PAT16: cfg_ok = !w10
                && (proto == rxa_pkg::RXA_PR_SONET
                || (proto == rxa_pkg::RXA_PR_CUSTOM && !plong));
            rxa_pkg::RXA_AL_PAT10: cfg_ok = w10
                && proto == rxa_pkg::RXA_PR_CUSTOM;
            rxa_pkg::RXA_AL_XAUI: cfg_ok = w10 && proto == rxa_pkg::RXA_PR_XAUI;
            rxa_pkg::RXA_AL_GBE:  cfg_ok = w10 && proto == rxa_pkg::RXA_PR_GBE;
            default: cfg_ok = 1'b0;
        endcase
    end

    // Pattern selection and per-offset matching.
    logic [9:0]  p10;
    logic [9:0]  mask10;
    logic [15:0] pat_s;
    logic [31:0] pat_l;
    assign p10    = (mode == rxa_pkg::RXA_AL_XAUI || mode == rxa_pkg::RXA_AL_GBE)
                    ? `RXA_COMMA : s_r.pat[25:16];
    assign mask10 = (m7 && mode == rxa_pkg::RXA_AL_PAT10) ? `RXA_MASK7 : `RXA_MASK10;
    assign pat_s  = s_r.pat[15:0];
    assign pat_l  = {s_r.pat[15:8], s_r.pat[15:8], s_r.pat[7:0], s_r.pat[7:0]};

    logic [9:0] hit;
    genvar o;
    generate
        for (o = 0; o < 10; o++) begin : g_off
            logic [9:0] sl;
            logic       h16;
            assign sl = s_r.hist[30-o +: 10];
            if (o < 8) begin : g_b
                assign h16 = plong ? (s_r.hist[8-o +: 32] == pat_l)
                                   : (s_r.hist[24-o +: 16] == pat_s);
            end else begin : g_n
                assign h16 = 1'b0;
            end
            assign hit[o] = w10 ? ((((sl ^ p10) & mask10) == 10'h000)
                                || (((sl ^ ~p10) & mask10) == 10'h000))
                                : h16;
        end
    endgenerate

    logic       found;
    logic [3:0] fidx;
    logic [3:0] wmax;
    always_comb begin
        found = 1'b0;
        fidx  = 4'h0;
        for (int i = 9; i >= 0; i--) begin
            if (hit[i] && (w10 || i < 8)) begin
                found = 1'b1;
                fidx  = 4'(i);
            end
        end
    end
    assign wmax = w10 ? 4'h9 : 4'h7;

    logic [7:0] rl_lim;
    logic [7:0] rl_step;
    assign rl_step = {3'h0, rl_field} + 8'h01;
    assign rl_lim  = 8'(rl_step * (w10 ? `RXA_RL_STEP10 : `RXA_RL_STEP8));

    logic bus_go;
    logic ctrl_wr;
    assign bus_go  = wb_cyc_in && wb_stb_in && s_r.ack;
    assign ctrl_wr = bus_go && wb_we_in && wb_adr_in == `RXA_ADR_CTRL;

    always_comb begin
        logic [3:0] sel;
        logic [9:0] w;
        s_nxt = s_r;
        sel   = s_r.offs;
        w     = 10'h000;
        // Bus slave: one wait state, ack held for one cycle.
        s_nxt.ack = wb_cyc_in && wb_stb_in && !s_r.ack;
        if (bus_go && wb_we_in) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_in[b] && wb_adr_in == `RXA_ADR_CTRL) begin
                    s_nxt.ctrl[b*8 +: 8] = wb_dat_in[b*8 +: 8];
                end
                if (wb_sel_in[b] && wb_adr_in == `RXA_ADR_PAT) begin
                    s_nxt.pat[b*8 +: 8] = wb_dat_in[b*8 +: 8];
                end
            end
            if (wb_adr_in == `RXA_ADR_STAT && wb_sel_in[0]
                && wb_dat_in[`RXA_S_VIOL]) begin
                s_nxt.viol = 1'b0;
            end
        end
        s_nxt.dat = 32'h0000_0000;
        if (wb_cyc_in && wb_stb_in && !s_r.ack) begin
            case (wb_adr_in)
                `RXA_ADR_CTRL: s_nxt.dat = s_r.ctrl;
                `RXA_ADR_PAT:  s_nxt.dat = s_r.pat;
                `RXA_ADR_STAT: s_nxt.dat = {24'h0, s_r.viol, !cfg_ok,
                    s_r.ksm == rxa_pkg::RXA_K_SYNC, s_r.aligned, s_r.offs[3:0] == 4'h0,
                    !used, s_r.lock_n, s_r.ltd};
                default:       s_nxt.dat = 32'h0000_0000;
            endcase
        end
        // Lock-mode selection.
        if (!used) begin
            s_nxt.ltd = 1'b0;
        end else if (f_data) begin
            s_nxt.ltd = 1'b1;
        end else if (f_ref) begin
            s_nxt.ltd = 1'b0;
        end else if (!s_r.ltd) begin
            s_nxt.ltd = freq_ok && phase_ok;
        end else begin
            s_nxt.ltd = freq_ok;
        end
        s_nxt.lock_n = !(used && ref_pll_lock_in);
        // Run length check; the event wins over a clear in the same cycle.
        s_nxt.viol_pulse = 1'b0;
        if (ser_valid_in && used) begin
            s_nxt.last_bit = ser_bit_in;
            if (ser_bit_in == s_r.last_bit) begin
                s_nxt.run = (s_r.run == 8'hFF) ? s_r.run : s_r.run + 8'h01;
            end else begin
                s_nxt.run = 8'h01;
            end
            if (s_nxt.run > rl_lim) begin
                s_nxt.viol       = 1'b1;
                s_nxt.viol_pulse = 1'b1;
            end
            // First received bit ends at the low end of each word.
            s_nxt.hist = {ser_bit_in, s_r.hist[39:1]};
            s_nxt.bcnt = (s_r.bcnt >= wmax) ? 4'h0 : s_r.bcnt + 4'h1;
        end
        s_nxt.pend = ser_valid_in && used && s_r.bcnt >= wmax;
        // Alignment.
        s_nxt.slip_d = slip_in;
        if (realign_in) begin
            s_nxt.aligned = 1'b0;
        end
        if (cfg_ok && used) begin
            case (mode)
                rxa_pkg::RXA_AL_SLIP: begin
                    if (slip_in && !s_r.slip_d) begin
                        s_nxt.offs = (s_r.offs >= wmax) ? 4'h0 : s_r.offs + 4'h1;
                    end
                end
                rxa_pkg::RXA_AL_PAT16: begin
                    if (s_r.pend && !s_r.aligned && !realign_in && found) begin
                        sel            = fidx;
                        s_nxt.offs     = fidx;
                        s_nxt.aligned  = 1'b1;
                    end
                end
                rxa_pkg::RXA_AL_PAT10: begin
                    if (s_r.pend && align_en_in && found) begin
                        sel           = fidx;
                        s_nxt.offs    = fidx;
                        s_nxt.aligned = 1'b1;
                    end
                end
                default: begin
                    // Commas at the held boundary build sync; one elsewhere loses it.
                    if (s_r.pend && found) begin
                        case (s_r.ksm)
                            rxa_pkg::RXA_K_LOSS: begin
                                sel        = fidx;
                                s_nxt.offs = fidx;
                                s_nxt.ksm  = rxa_pkg::RXA_K_ACQ;
                                s_nxt.kcnt = 2'h1;
                            end
                            rxa_pkg::RXA_K_ACQ: begin
                                if (hit[s_r.offs]) begin
                                    s_nxt.kcnt = s_r.kcnt + 2'h1;
                                    if (s_nxt.kcnt == `RXA_SYNC_COMMAS) begin
                                        s_nxt.ksm = rxa_pkg::RXA_K_SYNC;
                                    end
                                end else begin
                                    sel        = fidx;
                                    s_nxt.offs = fidx;
                                    s_nxt.kcnt = 2'h1;
                                end
                            end
                            rxa_pkg::RXA_K_SYNC: begin
                                if (!hit[s_r.offs]) begin
                                    s_nxt.ksm = rxa_pkg::RXA_K_LOSS;
                                end
                            end
                            default: s_nxt.ksm = rxa_pkg::RXA_K_LOSS;
                        endcase
                    end
                    s_nxt.aligned = s_nxt.ksm == rxa_pkg::RXA_K_SYNC;
                end
            endcase
        end
        if (mode != rxa_pkg::RXA_AL_XAUI && mode != rxa_pkg::RXA_AL_GBE) begin
            s_nxt.ksm  = rxa_pkg::RXA_K_LOSS;
            s_nxt.kcnt = 2'h0;
        end
        // Emit the word with its detect flag in the same beat.
        for (int i = 0; i < 10; i++) begin
            if (4'(i) == sel) begin
                w = w10 ? s_r.hist[30-i +: 10] : {2'h0, s_r.hist[32-i +: 8]};
            end
        end
        s_nxt.word.valid = s_r.pend;
        s_nxt.word.data  = s_r.pend ? w : s_r.word.data;
        s_nxt.word.det   = s_r.pend && hit[sel];
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            s_r        <= '0;
            s_r.ctrl   <= `RXA_CTRL_RST;
            s_r.pat    <= `RXA_PAT_RST;
            s_r.lock_n <= 1'b1;
            s_r.ksm    <= rxa_pkg::RXA_K_LOSS;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_out       = s_r.dat;
    assign wb_ack_out       = s_r.ack;
    assign lock_to_data_out = s_r.ltd;
    assign freq_locked_out  = s_r.ltd;
    assign rx_locked_n_out  = s_r.lock_n;
    assign powerdown_out    = !used;
    assign aligned_out      = s_r.aligned;
    assign sync_out         = s_r.ksm == rxa_pkg::RXA_K_SYNC;
    assign run_viol_out     = s_r.viol_pulse;
    assign word_out         = s_r.word;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    AST_FORCE_DATA: assert property (used && f_data && !ctrl_wr |=> lock_to_data_out)
        else $error("force-data did not select data lock");
    AST_FORCE_REF: assert property (f_ref && !f_data && !ctrl_wr |=> !lock_to_data_out)
        else $error("force-reference did not select reference lock");
    AST_AUTO_GATE: assert property (auto_m && !lock_to_data_out && !(freq_ok && phase_ok)
        && !ctrl_wr |=> !lock_to_data_out)
        else $error("switched to data lock without ppm and phase match");
    AST_LOCK_N: assert property (used && ref_pll_lock_in ##1 used |-> !rx_locked_n_out)
        else $error("lock flag not low while reference lock held");
    AST_PD: assert property (!used |=> !lock_to_data_out && !freq_locked_out)
        else $error("unused channel not held down");
    AST_SLIP_ONE: assert property (mode == rxa_pkg::RXA_AL_SLIP && cfg_ok && used
        && $rose(slip_in) && !ctrl_wr && s_r.offs < wmax
        |=> s_r.offs == $past(s_r.offs) + 4'h1)
        else $error("slip did not move boundary by one bit");
    AST_SLIP_HELD: assert property (mode == rxa_pkg::RXA_AL_SLIP && slip_in && s_r.slip_d
        && !ctrl_wr |=> $stable(s_r.offs))
        else $error("held slip moved the boundary");
    AST_SLIP_PROTO: assert property (mode == rxa_pkg::RXA_AL_SLIP
        && proto == rxa_pkg::RXA_PR_XAUI && !ctrl_wr |=> $stable(s_r.offs))
        else $error("slip acted under a forbidden protocol");
    AST_P10_EN: assert property (mode == rxa_pkg::RXA_AL_PAT10 && !align_en_in
        && !ctrl_wr |=> $stable(s_r.offs))
        else $error("10-bit aligner moved while disabled");
    AST_DET_WORD: assert property (word_out.det && mode == rxa_pkg::RXA_AL_PAT10 && !m7
        |-> word_out.data == p10 || word_out.data == ~p10)
        else $error("detect flag on a word without the pattern");
    AST_RUNLEN: assert property (used && ser_valid_in && ser_bit_in == s_r.last_bit
        && s_r.run >= rl_lim && s_r.run != 8'hFF |=> run_viol_out)
        else $error("run length over limit not flagged");
endmodule // rxa_word_align_top

/* shared/rxa_map.svh */
// Offsets, field positions, reset values and fixed figures of the receive aligner.
// Assumes a Wishbone slave with a 4-bit byte address and 32-bit data.
`ifndef RXA_MAP_SVH
`define RXA_MAP_SVH
`define RXA_ADR_CTRL     4'h0
`define RXA_ADR_PAT      4'h4
`define RXA_ADR_STAT     4'h8
`define RXA_CTRL_RST     32'h0001_F004
`define RXA_PAT_RST      32'h0000_0000
`define RXA_C_FREF       0
`define RXA_C_FDATA      1
`define RXA_C_USED       2
`define RXA_C_W10        3
`define RXA_C_PPM        4
`define RXA_C_MODE       6
`define RXA_C_PROTO      9
`define RXA_C_LONG       11
`define RXA_C_MATCH7     12
`define RXA_C_RUNLEN     13
`define RXA_S_VIOL       7
`define RXA_PPM_125      11'h07D
`define RXA_PPM_250      11'h0FA
`define RXA_PPM_500      11'h1F4
`define RXA_PPM_1000     11'h3E8
`define RXA_PHASE_MUI    10'h050
`define RXA_RL_STEP10    8'h05
`define RXA_RL_STEP8     8'h04
`define RXA_COMMA        10'h17C
`define RXA_MASK7        10'h07F
`define RXA_MASK10       10'h3FF
`define RXA_SYNC_COMMAS  2'h3
`endif

/* shared/rxa_pkg.sv */
// Types shared by the receive aligner.
// Assumes the constants of rxa_map.svh.
package rxa_pkg;
    typedef enum logic [2:0] {
        RXA_AL_SLIP  = 3'h0,
        RXA_AL_PAT16 = 3'h1,
        RXA_AL_PAT10 = 3'h2,
        RXA_AL_XAUI  = 3'h3,
        RXA_AL_GBE   = 3'h4
    } rxa_align_t;
    typedef enum logic [1:0] {
        RXA_PR_CUSTOM = 2'h0,
        RXA_PR_SONET  = 2'h1,
        RXA_PR_XAUI   = 2'h2,
        RXA_PR_GBE    = 2'h3
    } rxa_proto_t;
    typedef enum logic [2:0] {
        RXA_K_LOSS = 3'b001,
        RXA_K_ACQ  = 3'b010,
        RXA_K_SYNC = 3'b100
    } rxa_ksm_t;
    typedef struct packed {
        logic [9:0] data;
        logic       det;
        logic       valid;
    } rxa_word_t;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] pat;
        logic [31:0] dat;
        logic        ack;
        logic        ltd;
        logic        lock_n;
        logic        viol;
        logic        viol_pulse;
        logic [39:0] hist;
        logic [3:0]  bcnt;
        logic        pend;
        logic [3:0]  offs;
        logic        aligned;
        logic        slip_d;
        rxa_ksm_t    ksm;
        logic [1:0]  kcnt;
        logic        last_bit;
        logic [7:0]  run;
        rxa_word_t   word;
    } rxa_st_t;
endpackage

/* verification/rxa_serial_tx.sv */
// Model of the remote serial transmitter feeding the recovered bit stream.
// Assumes the bench calls send from its own process, one frame at a time.
`timescale 1ns/1ns
module rxa_serial_tx (
    // Clock
    input  wire logic mclk_in,
    // Serial stream
    output logic      ser_bit_out,
    output logic      ser_valid_out
);
    initial begin
        ser_bit_out   = 1'b0;
        ser_valid_out = 1'b0;
    end
    // Between frames the line shows the inverse of the last bit, so stale data never matches.
    task automatic send(input logic [31:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk_in);
            ser_bit_out   <= bits[i];
            ser_valid_out <= 1'b1;
        end
        @(posedge mclk_in);
        ser_valid_out <= 1'b0;
        ser_bit_out   <= ~bits[n-1];
    endtask
endmodule // rxa_serial_tx

/* verification/rxa_word_align_tb_top.sv */
// Self-checking bench for the receive aligner: registers, lock mode, slips, framing.
// Assumes rxa_word_align_top and rxa_serial_tx; bus is classic Wishbone.
`timescale 1ns/1ns
module rxa_word_align_tb_top;
    logic               mclk = 1'b0, rst_n = 1'b0;
    logic               cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]         adr = 4'h0, sel = 4'h0;
    logic [31:0]        wdat = 32'h0, rdat, q;
    logic               ack, ltd, frq, lock_n, pdn, algn, sync, viol, sbit, sval;
    logic [10:0]        ppm = 11'h000;
    logic [9:0]         phs = 10'h000;
    logic               ref_lock = 1'b0, slip = 1'b0, realign = 1'b0, al_en = 1'b0;
    rxa_pkg::rxa_word_t word;
    int                 bad_count = 0, comparisons = 0;
    initial forever #50 mclk = ~mclk;
    rxa_word_align_top dut_u (.mclk_in(mclk), .rst_n_in(rst_n), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .ppm_err_in(ppm), .phase_err_mui_in(phs),
        .ref_pll_lock_in(ref_lock), .ser_bit_in(sbit), .ser_valid_in(sval), .slip_in(slip),
        .realign_in(realign), .align_en_in(al_en), .lock_to_data_out(ltd),
        .freq_locked_out(frq), .rx_locked_n_out(lock_n), .powerdown_out(pdn),
        .aligned_out(algn), .sync_out(sync), .run_viol_out(viol), .word_out(word));
    rxa_serial_tx tx_u (.mclk_in(mclk), .ser_bit_out(sbit), .ser_valid_out(sval));
    task automatic results();
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // One classic cycle; the request stands until ack is sampled high.
    // Only the watchdog ends a wait for ack, so no answer time is assumed here.
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; wdat <= d;
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic t_reset_values();
        chk(lock_n, 1'b1, "lock_n at reset");
        wb(1'b0, 4'h0, 32'h0); chk(q, 32'h0001_F004, "ctrl reset");
        wb(1'b0, 4'h4, 32'h0); chk(q, 32'h0, "pat reset");
        wb(1'b1, 4'hC, 32'hFFFF_FFFF); wb(1'b0, 4'hC, 32'h0); chk(q, 32'h0, "unmapped");
    endtask
    // Each row: override bits and ppm field, loop errors, expected lock-to-data.
    task automatic t_lock_mode();
        logic [5:0]  c [6] = '{6'h00, 6'h00, 6'h30, 6'h01, 6'h00, 6'h03};
        logic [10:0] p [6] = '{11'd100, 11'd200, 11'd900, 11'd10, 11'd10, 11'd1500};
        logic [9:0]  f [6] = '{10'd50, 10'd50, 10'd80, 10'd10, 10'd81, 10'd999};
        logic        e [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        // Loop errors change before the mode so that the phase gate is met from reference lock.
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk);
            ppm <= p[i]; phs <= f[i];
            wb(1'b1, 4'h0, 32'h0001_F004 | c[i]);
            cycles(4);
            chk(ltd, e[i], "lock to data");
            chk(frq, e[i], "data lock status");
        end
        @(posedge mclk);
        ppm <= 11'd0; phs <= 10'd0;
        wb(1'b1, 4'h0, 32'h0001_F004);
    endtask
    task automatic t_ref_lock_power();
        ref_lock <= 1'b1; cycles(3); chk(lock_n, 1'b0, "ref locked");
        @(posedge mclk);
        ref_lock <= 1'b0; cycles(3); chk(lock_n, 1'b1, "ref unlocked");
        wb(1'b1, 4'h0, 32'h0001_F000); cycles(2); chk(pdn, 1'b1, "unused powered down");
        wb(1'b1, 4'h0, 32'h0001_F004); cycles(2); chk(pdn, 1'b0, "used powered up");
    endtask
    // Catches the next word while the transmitter is still sending.
    task automatic grab(input logic want_det, output rxa_pkg::rxa_word_t w);
        int n = 0;
        w = '0;
        while (n < 200 && !(word.valid === 1'b1 && (word.det === 1'b1 || !want_det))) begin
            @(negedge mclk);
            n++;
        end
        w = word;
        if (n >= 200) begin
            chk(1'b0, 1'b1, "no word");
            results();
        end
    endtask
    task automatic t_lsb_first();
        rxa_pkg::rxa_word_t w;
        fork
            tx_u.send(32'hA5, 8);
            grab(1'b0, w);
        join
        chk(w.data, 10'h0A5, "first bit in lsb");
    endtask
    task automatic t_slip();
        slip <= 1'b1; cycles(4);
        @(posedge mclk);
        slip <= 1'b0; cycles(1);
        wb(1'b0, 4'h8, 32'h0); chk(q[3], 1'b0, "one slip moved boundary");
        for (int i = 0; i < 7; i++) begin
            @(posedge mclk);
            slip <= 1'b1;
            @(posedge mclk);
            slip <= 1'b0;
        end
        wb(1'b0, 4'h8, 32'h0); chk(q[3], 1'b1, "eight slips wrap");
        wb(1'b1, 4'h0, 32'h0001_F404);
        @(posedge mclk);
        slip <= 1'b1;
        @(posedge mclk);
        slip <= 1'b0;
        wb(1'b0, 4'h8, 32'h0); chk(q[3], 1'b1, "slip refused under XAUI");
    endtask
    task automatic t_pat10();
        rxa_pkg::rxa_word_t w;
        wb(1'b1, 4'h4, {6'h00, 10'h17C, 16'h0000});
        wb(1'b1, 4'h0, 32'h0000_E08C);
        al_en <= 1'b1;
        fork
            tx_u.send({2'b00, 10'h17C, 10'h283, 10'h155}, 32);
            grab(1'b1, w);
        join
        chk(w.data, 10'h283, "negative disparity hit");
        cycles(25);
        chk(algn, 1'b1, "aligned while enabled");
    endtask
    // Three commas at one boundary, then padding so the last one reaches a word edge.
    task automatic t_xaui();
        wb(1'b1, 4'h0, 32'h0000_E4CC);
        tx_u.send({2'b00, 10'h17C, 10'h283, 10'h17C}, 30);
        tx_u.send(32'h0000_0155, 10);
        cycles(3);
        chk(sync, 1'b1, "three commas give sync");
        chk(algn, 1'b1, "sync reported as aligned");
        wb(1'b0, 4'h8, 32'h0); chk(q[5], 1'b1, "sync status");
    endtask
    // Limit is 40 in the 10-bit path; 48 equal bits run past it.
    task automatic t_runlen();
        int n;
        tx_u.send(32'hFFFF_FFFF, 32);
        fork
            tx_u.send(32'hFFFF_FFFF, 16);
            begin
                n = 0;
                while (viol !== 1'b1 && n < 40) begin
                    @(negedge mclk);
                    n++;
                end
                chk(viol, 1'b1, "run length pulse");
            end
        join
        wb(1'b0, 4'h8, 32'h0); chk(q[7], 1'b1, "violation held");
        wb(1'b1, 4'h8, 32'h0000_0080);
        wb(1'b0, 4'h8, 32'h0); chk(q[7], 1'b0, "violation cleared");
    endtask
    // The aligned flag left by the comma test must be cleared by realign before a 16-bit search.
    task automatic t_pat16();
        wb(1'b1, 4'h4, 32'h0000_28F6);
        wb(1'b1, 4'h0, 32'h0000_E044);
        @(posedge mclk);
        realign <= 1'b1;
        @(posedge mclk);
        realign <= 1'b0;
        cycles(1);
        chk(algn, 1'b0, "realign reopens search");
        tx_u.send(32'h0000_28F6, 24);
        cycles(3);
        chk(algn, 1'b1, "16-bit pattern found");
    endtask
    initial begin
        #2000000;
        chk(1'b0, 1'b1, "watchdog");
        results();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset_values();
        t_lsb_first();
        t_lock_mode();
        t_ref_lock_power();
        t_slip();
        t_pat10();
        t_xaui();
        t_runlen();
        t_pat16();
        results();
    end
endmodule // rxa_word_align_tb_top
